// >>> bench/asr_station.sv
// ==========
// far station sharing the serial line
module asr_station #(
  parameter int BIT_CYC = 16
) (
  input  wire logic pclk,
  output logic      line_out,
  input  wire logic line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pclk cycles per bit cell, changed by the bench for slower bit clocks
  int bit_cyc = BIT_CYC;
  // line idles high between frames
  initial line_out = 1'b1;
  // one bit cell, changed just after an edge
  task automatic put(input logic b);
    line_out <= b;
    repeat (bit_cyc) @(posedge pclk);
  endtask : put
  // start, data lsb first, optional extra bit, stops, idle high
  task automatic send(input logic [7:0] d, input int nb, input logic hx,
                      input logic xb, input logic s1, input logic two);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (hx) put(xb);
    put(s1);
    if (two) put(1'b1);
    line_out <= 1'b1;
  endtask : send
  // sample a frame from the device at mid bit
  task automatic get(input int nb, output logic [7:0] d, output logic xb,
                     output logic sb, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (line_in !== 1'b0 && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge pclk);
    ok = (line_in === 1'b0) && (n < 4000);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bit_cyc) @(posedge pclk);
      d[i] = line_in;
    end
    repeat (bit_cyc) @(posedge pclk);
    xb = line_in;
    repeat (bit_cyc) @(posedge pclk);
    sb = line_in;
  endtask : get
endmodule : asr_station

// >>> bench/asr_top_tb.sv
module asr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  // ==========
  // constants and signals
  localparam int          BIT_CYC = 16; // divider 0: one tick per pclk
  localparam logic [31:0] S_TE    = 32'h1 << SB_TX_EMPTY_FLAG;
  localparam logic [31:0] S_TN    = 32'h1 << SB_TX_END_FLAG;
  localparam logic [31:0] S_RF    = 32'h1 << SB_RX_FULL_FLAG;
  localparam logic [31:0] S_OR    = 32'h1 << SB_OVERRUN_FLAG;
  localparam logic [31:0] S_FE    = 32'h1 << SB_FER;
  localparam logic [31:0] S_PE    = 32'h1 << SB_PER;
  localparam logic [31:0] S_MB    = 32'h1 << SB_MPB;
  localparam logic [31:0] S_MT    = 32'h1 << SB_MP_BIT_TO_SEND;
  localparam logic [31:0] CLR     = S_TE | S_TN; // keeps tx flags, clears rx flags
  localparam logic [31:0] M_FL    = 32'h0000_00FC;
  localparam logic [31:0] M_ALL   = 32'hFFFF_FFFF;
  localparam logic [31:0] SKIP    = 32'h1 << CB_SKIP;
  localparam logic [31:0] RUN     = (32'h1 << CB_RE) | (32'h1 << CB_TE) | (32'h1 << CB_RIE)
                                  | (32'h1 << CB_TIE) | (32'h1 << CB_TX_END_IRQ_ENABLE);
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        sck_in  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd_v;
  logic        pready, pslverr, rxd, txd, err_v, gx, gs, ok;
  logic        rx_full_irq, rx_error_irq, tx_empty_irq, tx_end_irq, rx_dma_req;
  logic [7:0]  gd;
  int          err_count = 0;
  int          n_tests   = 0;
  int          dma_cnt   = 0;
  int          d0;
  // ==========
  // design and far station
  asr_top #(.ADDR_W(8)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .sck_in, .rx_full_irq, .rx_error_irq,
    .tx_empty_irq, .tx_end_irq, .rx_dma_req
  );
  asr_station #(.BIT_CYC(BIT_CYC)) peer (.pclk, .line_out(rxd), .line_in(txd));
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // free-running 16x clock on sck_in, one rise every two pclk
  always @(posedge pclk)
    sck_in <= ~sck_in;
  // count one-cycle dma pulses
  always @(posedge pclk)
    if (rx_dma_req === 1'b1) dma_cnt <= dma_cnt + 1;
  // ==========
  // compare, bus and frame tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit
  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait states end only by pready; the watchdog guards a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r & m, exp, "register read");
  endtask : rc
  task automatic rx(input logic [7:0] d, input int nb, input logic hx, input logic xb,
                    input logic s1, input logic two);
    peer.send(d, nb, hx, xb, s1, two);
    repeat (4) @(posedge pclk);
  endtask : rx
  // one transmitted frame, captured by the far station
  task automatic tx_one(input logic [31:0] fmt, input logic [7:0] d, input int nb,
                        input logic [31:0] mt, input logic ex);
    wr(OFS_FMT, fmt);
    rc(OFS_STS, S_TN, S_TN);
    wr(OFS_STS, CLR | mt);
    wr(OFS_TDR, {24'h0, d});
    fork
      peer.get(nb, gd, gx, gs, ok);
      begin
        wr(OFS_STS, S_TN | mt);
        @(posedge pclk);
        chk_bit(tx_empty_irq, 1'b1, "tx empty irq");
        chk_bit(tx_end_irq, 1'b0, "tx end irq busy");
      end
    join
    chk_word({24'h0, gd}, {24'h0, d}, "tx data");
    chk_bit(gx, ex, "tx extra bit");
    chk_bit(ok & gs, 1'b1, "tx start or stop");
    chk_bit(tx_end_irq, 1'b1, "tx end irq");
    repeat (2 * BIT_CYC) @(posedge pclk);
    chk_bit(txd, 1'b1, "tx idle level");
  endtask : tx_one
  // verdict and end of run
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ==========
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
  // ==========
  // test sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(OFS_STS, S_TE | S_TN, M_ALL);
    rc(OFS_CTL, {24'h0, CTL_RST}, M_ALL);
    rc(OFS_FMT, {24'h0, FMT_RST}, M_ALL);
    apb(1'b0, 8'h1C, 32'h0, rd_v, err_v);
    chk_bit(err_v, 1'b1, "unmapped error");
    chk_word(rd_v, 32'h0, "unmapped data");
    wr(OFS_DIV, 32'h0);
    wr(OFS_CTL, RUN);
    rc(OFS_CTL, RUN, M_ALL);
    // clean frame, overrun, then a frame refused while an error stands
    d0 = dma_cnt;
    rx(8'hA5, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_RDR, 32'hA5, M_ALL);
    rc(OFS_STS, CLR | S_RF, M_FL);
    chk_bit(rx_full_irq, 1'b1, "rx full irq");
    chk_word(dma_cnt - d0, 32'h1, "dma pulses");
    rx(8'h3C, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_RDR, 32'hA5, M_ALL);
    rc(OFS_STS, CLR | S_RF | S_OR, M_FL);
    chk_bit(rx_error_irq, 1'b1, "rx error irq");
    wr(OFS_STS, CLR | S_OR);
    rx(8'h11, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_STS, CLR | S_OR, M_FL);
    rc(OFS_RDR, 32'hA5, M_ALL);
    wr(OFS_STS, CLR);
    chk_bit(rx_error_irq, 1'b0, "rx error irq clear");
    // framing error with two stop bits configured
    wr(OFS_FMT, 32'h1 << FB_STOP2);
    rx(8'h5A, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    rc(OFS_RDR, 32'h5A, M_ALL);
    rc(OFS_STS, CLR | S_FE, M_FL);
    chk_bit(rx_error_irq, 1'b1, "framing irq");
    wr(OFS_STS, CLR);
    // even parity broken, then odd parity kept
    wr(OFS_FMT, 32'h1 << FB_PE);
    rx(8'h03, 8, 1'b1, 1'b1, 1'b1, 1'b0);
    rc(OFS_RDR, 32'h03, M_ALL);
    rc(OFS_STS, CLR | S_PE, M_FL);
    wr(OFS_STS, CLR);
    wr(OFS_FMT, (32'h1 << FB_PE) | (32'h1 << FB_ODD));
    rx(8'h07, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rc(OFS_STS, CLR | S_RF, M_FL);
    wr(OFS_STS, CLR);
    // 7-bit character with the rx irq inhibited
    wr(OFS_FMT, 32'h1 << FB_CHR);
    wr(OFS_PORT, 32'h1 << PB_INH);
    d0 = dma_cnt;
    rx(8'hFF, 7, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_RDR, 32'h7F, M_ALL);
    chk_bit(rx_full_irq, 1'b0, "inhibited irq");
    chk_word(dma_cnt - d0, 32'h1, "dma pulses");
    wr(OFS_PORT, 32'h0);
    wr(OFS_STS, CLR);
    // slower bit clocks: external 16x clock, then divider 1
    peer.bit_cyc = 2 * BIT_CYC;
    wr(OFS_FMT, 32'h1 << FB_EXT);
    rx(8'hC3, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_RDR, 32'hC3, M_ALL);
    rc(OFS_STS, CLR | S_RF, M_FL);
    wr(OFS_STS, CLR);
    wr(OFS_FMT, 32'h0);
    wr(OFS_DIV, 32'h1);
    rc(OFS_DIV, 32'h1, M_ALL);
    rx(8'h6E, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(OFS_RDR, 32'h6E, M_ALL);
    wr(OFS_STS, CLR);
    wr(OFS_DIV, 32'h0);
    peer.bit_cyc = BIT_CYC;
    // multiprocessor: foreign data, own id, then payload overrun
    wr(OFS_FMT, (32'h1 << FB_MP) | (32'h1 << FB_PE));
    wr(OFS_CTL, RUN | SKIP);
    rx(8'h23, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rc(OFS_STS, CLR | S_RF, M_FL);
    rx(8'h24, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rc(OFS_STS, CLR | S_RF, M_FL);
    rc(OFS_RDR, 32'h23, M_ALL);
    rc(OFS_CTL, RUN | SKIP, M_ALL);
    wr(OFS_STS, CLR);
    rx(8'h41, 8, 1'b1, 1'b1, 1'b1, 1'b0);
    rc(OFS_CTL, RUN, M_ALL);
    rc(OFS_STS, CLR | S_RF | S_MB, 32'h0000_00FE);
    rc(OFS_RDR, 32'h41, M_ALL);
    rx(8'hAA, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    rc(OFS_STS, CLR | S_RF | S_OR, M_FL);
    wr(OFS_STS, CLR);
    // transmit: 8-bit even parity, then 7-bit id with mp bit 1
    tx_one(32'h1 << FB_PE, 8'h96, 8, 32'h0, 1'b0);
    tx_one((32'h1 << FB_MP) | (32'h1 << FB_CHR), 8'h35, 7, S_MT, 1'b1);
    wrap_up();
  end
endmodule : asr_top_tb

// >>> rtl/asr_pkg.sv
package asr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_FMT  = 8'h00;
  localparam logic [7:0] OFS_DIV  = 8'h04;
  localparam logic [7:0] OFS_CTL  = 8'h08;
  localparam logic [7:0] OFS_TDR  = 8'h0C;
  localparam logic [7:0] OFS_STS  = 8'h10;
  localparam logic [7:0] OFS_RDR  = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;
  // ==========================================================
  // field positions
  localparam int FB_EXT = 0, FB_MP = 2, FB_STOP2 = 3, FB_ODD = 4, FB_PE = 5, FB_CHR = 6;
  localparam int CB_TX_END_IRQ_ENABLE = 2, CB_SKIP = 3, CB_RE = 4, CB_TE = 5, CB_RIE = 6, CB_TIE = 7;
  localparam int SB_MP_BIT_TO_SEND = 0, SB_MPB = 1, SB_TX_END_FLAG = 2, SB_PER = 3, SB_FER = 4;
  localparam int SB_OVERRUN_FLAG = 5, SB_RX_FULL_FLAG = 6, SB_TX_EMPTY_FLAG = 7;
  localparam int PB_INH = 0;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0]  FMT_RST  = 8'h00;
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0000;
  localparam logic [7:0]  STS_RST  = 8'h84;
  localparam logic [3:0]  MID_TICK  = 4'h7;
  localparam logic [3:0]  LAST_TICK = 4'hF;
  // ==========================================================
  // state machines
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asr_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asr_tx_st_t;
endpackage : asr_pkg

// >>> rtl/asr_top.sv
// The implementer's own choices: the register offsets and the APB register port.
module asr_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd,
  input  wire logic              sck_in,
  output logic                   rx_full_irq,
  output logic                   rx_error_irq,
  output logic                   tx_empty_irq,
  output logic                   tx_end_irq,
  output logic                   rx_dma_req
);
  import asr_pkg::*;

  typedef struct packed {
    logic [7:0]  fmt;
    logic [7:0]  ctl;
    logic [15:0] div;
    logic        inh;
    logic [7:0]  tdr;
    logic [7:0]  rdr;
    logic [7:0]  sts;
    logic [15:0] baud_cnt;
    logic        sck_prev;
    asr_rx_st_t  rx_st;
    logic [3:0]  tick_cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  rsr;
    logic        par_bit;
    logic        dma;
    logic [31:0] prdata;
  } asr_s_t;

  asr_s_t    q, d;
  asr_tx_if  tif ();
  logic      tick_c;
  logic      wr_c;
  logic      hit_c;
  logic      err_c;
  logic      eval_c;
  logic      foreign_c;
  logic      fer_c;
  logic      per_c;
  logic [7:0] rdv_c;

  // ==========================================================
  // transmitter
  asr_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.tx)
  );

  // transmit control toward the shifter
  assign tif.tick    = tick_c;
  assign tif.te      = q.ctl[CB_TE];
  assign tif.pending = ~q.sts[SB_TX_EMPTY_FLAG] & q.ctl[CB_TE];
  assign tif.data    = q.tdr;
  assign tif.chr7    = q.fmt[FB_CHR];
  assign tif.pe      = q.fmt[FB_PE];
  assign tif.odd     = q.fmt[FB_ODD];
  assign tif.mp      = q.fmt[FB_MP];
  assign tif.mp_bit_to_send    = q.sts[SB_MP_BIT_TO_SEND];
  assign tif.stop2   = q.fmt[FB_STOP2];

  // ==========================================================
  // bus decode and read mux
  always_comb
  begin
    hit_c = 1'b1;
    rdv_c = 8'h00;
    if (paddr[7:0] == OFS_FMT)
      rdv_c = q.fmt;
    else if (paddr[7:0] == OFS_DIV)
      rdv_c = 8'h00;
    else if (paddr[7:0] == OFS_CTL)
      rdv_c = q.ctl;
    else if (paddr[7:0] == OFS_TDR)
      rdv_c = q.tdr;
    else if (paddr[7:0] == OFS_STS)
      rdv_c = q.sts;
    else if (paddr[7:0] == OFS_RDR)
      rdv_c = q.rdr;
    else if (paddr[7:0] == OFS_PORT)
      rdv_c = {7'h00, q.inh};
    else
      hit_c = 1'b0;
    if (ADDR_W > 8)
      hit_c = hit_c && (paddr >> 8) == '0;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_c;
  assign wr_c    = psel & penable & pwrite & hit_c;
  assign err_c   = q.sts[SB_OVERRUN_FLAG] | q.sts[SB_FER] | q.sts[SB_PER];

  // bit-clock tick from registered state and the sck_in input only, so no path runs back from the shifter
  assign tick_c = q.fmt[FB_EXT] ? (sck_in & ~q.sck_prev) : (q.baud_cnt >= q.div);

  // ==========================================================
  // registers, baud tick and receiver
  always_comb
  begin
    d = q;
    eval_c = 1'b0;
    foreign_c = 1'b0;
    fer_c = 1'b0;
    per_c = 1'b0;
    // read data captured in the setup phase, so zero wait states
    if (psel && !penable && !pwrite)
      d.prdata = (paddr[7:0] == OFS_DIV) ? {16'h0000, q.div} : {24'h000000, rdv_c};
    // software writes; status flags clear on a written 0
    if (wr_c)
    begin
      if (paddr[7:0] == OFS_FMT)
        d.fmt = pwdata[7:0];
      else if (paddr[7:0] == OFS_DIV)
        d.div = pwdata[15:0];
      else if (paddr[7:0] == OFS_CTL)
        d.ctl = pwdata[7:0];
      else if (paddr[7:0] == OFS_TDR)
        d.tdr = pwdata[7:0];
      else if (paddr[7:0] == OFS_STS)
      begin
        d.sts[7:2] = q.sts[7:2] & pwdata[7:2];
        d.sts[SB_MP_BIT_TO_SEND] = pwdata[SB_MP_BIT_TO_SEND];
      end
      else if (paddr[7:0] == OFS_PORT)
        d.inh = pwdata[PB_INH];
    end
    // sixteen ticks per bit, external clock or divider
    d.sck_prev = sck_in;
    if (!q.fmt[FB_EXT])
      d.baud_cnt = tick_c ? 16'h0000 : q.baud_cnt + 16'h0001;
    // receive sequencer
    if (tick_c)
      d.tick_cnt = q.tick_cnt + 4'h1;
    case (q.rx_st)
      RX_IDLE:
        if (q.ctl[CB_RE] && !err_c && tick_c && !rxd)
        begin
          d.rx_st = RX_START;
          d.tick_cnt = '0;
        end
      RX_START:
        // confirm start at mid bit, then count whole bits
        if (tick_c && q.tick_cnt == MID_TICK)
        begin
          d.rx_st = rxd ? RX_IDLE : RX_DATA;
          d.tick_cnt = '0;
          d.bit_idx = '0;
          d.rsr = '0;
        end
      RX_DATA:
        if (tick_c && q.tick_cnt == LAST_TICK)
        begin
          d.rsr[q.bit_idx] = rxd;
          if (q.bit_idx == (q.fmt[FB_CHR] ? 3'd6 : 3'd7))
            d.rx_st = (q.fmt[FB_MP] || q.fmt[FB_PE]) ? RX_PAR : RX_STOP;
          else
            d.bit_idx = q.bit_idx + 3'd1;
        end
      RX_PAR:
        if (tick_c && q.tick_cnt == LAST_TICK)
        begin
          d.par_bit = rxd;
          d.rx_st = RX_STOP;
        end
      default:
        // only the first stop bit is examined
        if (tick_c && q.tick_cnt == LAST_TICK)
        begin
          eval_c = 1'b1;
          d.rx_st = RX_IDLE;
        end
    endcase
    // end-of-frame checks
    if (eval_c)
    begin
      foreign_c = q.fmt[FB_MP] && q.ctl[CB_SKIP] && !q.par_bit;
      if (foreign_c)
      begin
        // frame for another station: no error flags
        if (!q.sts[SB_RX_FULL_FLAG])
        begin
          d.rdr = q.rsr;
          d.sts[SB_RX_FULL_FLAG] = 1'b1;
        end
      end
      else
      begin
        if (q.fmt[FB_MP])
        begin
          d.sts[SB_MPB] = q.par_bit;
          if (q.par_bit)
            d.ctl[CB_SKIP] = 1'b0;
        end
        fer_c = ~rxd;
        // parity ignored in mp format
        per_c = q.fmt[FB_PE] && !q.fmt[FB_MP]
          && ((^q.rsr ^ q.par_bit) != q.fmt[FB_ODD]);
        if (q.sts[SB_RX_FULL_FLAG])
          d.sts[SB_OVERRUN_FLAG] = 1'b1;
        else
        begin
          d.rdr = q.rsr;
          if (fer_c)
            d.sts[SB_FER] = 1'b1;
          if (per_c)
            d.sts[SB_PER] = 1'b1;
          if (!fer_c && !per_c)
            d.sts[SB_RX_FULL_FLAG] = 1'b1;
        end
      end
    end
    if (!q.ctl[CB_RE])
      d.rx_st = RX_IDLE;
    // transmit events; load re-arms tx empty
    if (tif.load)
    begin
      d.sts[SB_TX_EMPTY_FLAG] = 1'b1;
      d.sts[SB_TX_END_FLAG] = 1'b0;
    end
    if (tif.done)
      d.sts[SB_TX_END_FLAG] = 1'b1;
    if (!q.ctl[CB_TE])
      d.sts[SB_TX_EMPTY_FLAG] = 1'b1;
    // dma request on each rise of rx full
    d.dma = d.sts[SB_RX_FULL_FLAG] & ~q.sts[SB_RX_FULL_FLAG];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.fmt <= FMT_RST;
      q.ctl <= CTL_RST;
      q.div <= DIV_RST;
      q.sts <= STS_RST;
      q.rx_st <= RX_IDLE;
    end
    else
      q <= d;
  end

  // ==========================================================
  // outputs
  assign prdata = q.prdata;
  assign txd = tif.txd;
  assign rx_dma_req = q.dma;
  // interrupt requests
  assign rx_full_irq  = q.sts[SB_RX_FULL_FLAG] & q.ctl[CB_RIE] & ~q.inh;
  assign rx_error_irq = err_c & q.ctl[CB_RIE];
  assign tx_empty_irq = q.sts[SB_TX_EMPTY_FLAG] & q.ctl[CB_TIE];
  assign tx_end_irq   = q.sts[SB_TX_END_FLAG] & q.ctl[CB_TX_END_IRQ_ENABLE];

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rx_start;
    q.rx_st == RX_IDLE && q.ctl[CB_RE] && !err_c && tick_c && !rxd |=> q.rx_st == RX_START;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("start edge missed");

  property p_dma;
    $rose(q.sts[SB_RX_FULL_FLAG]) |-> rx_dma_req ##1 !rx_dma_req;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request not one pulse");

  property p_full_irq;
    $rose(q.sts[SB_RX_FULL_FLAG]) && q.ctl[CB_RIE] && !q.inh |-> rx_full_irq;
  endproperty
  a_full_irq: assert property (p_full_irq) else $error("rx full irq missing");

  property p_err_irq;
    $rose(q.sts[SB_OVERRUN_FLAG]) && q.ctl[CB_RIE] |-> rx_error_irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("rx error irq missing");

  property p_ovr_keep;
    eval_c && !foreign_c && q.sts[SB_RX_FULL_FLAG] |=> q.rdr == $past(q.rdr) && q.sts[SB_OVERRUN_FLAG];
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun overwrote data");

  property p_fer_store;
    eval_c && !foreign_c && !q.sts[SB_RX_FULL_FLAG] && !rxd
      |=> q.sts[SB_FER] && !q.sts[SB_RX_FULL_FLAG] && q.rdr == $past(q.rsr);
  endproperty
  a_fer_store: assert property (p_fer_store) else $error("framing error handling");

  property p_err_block;
    err_c && q.rx_st == RX_IDLE |=> q.rx_st == RX_IDLE;
  endproperty
  a_err_block: assert property (p_err_block) else $error("receive after error");

  property p_skip_clr;
    eval_c && q.fmt[FB_MP] && q.par_bit |=> !q.ctl[CB_SKIP];
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip enable not cleared");

  property p_load_empty;
    tif.load |=> q.sts[SB_TX_EMPTY_FLAG] && !q.sts[SB_TX_END_FLAG];
  endproperty
  a_load_empty: assert property (p_load_empty) else $error("tx empty not set on load");

  c_rx_full: cover property ($rose(q.sts[SB_RX_FULL_FLAG]));
  c_overrun: cover property ($rose(q.sts[SB_OVERRUN_FLAG]));
  c_foreign: cover property (eval_c && foreign_c);
endmodule : asr_top

// >>> rtl/asr_tx.sv
module asr_tx (
  input  wire logic pclk,
  input  wire logic presetn,
  asr_tx_if.tx      tif
);
  import asr_pkg::*;

  typedef struct packed {
    asr_tx_st_t st;
    logic [3:0] cnt;
    logic [2:0] idx;
    logic [7:0] sr;
    logic       par;
    logic       nxt;
    logic       txd;
  } asr_tx_s_t;

  asr_tx_s_t q, d;
  logic      bit_end;
  logic      to_stop;

  // ==========================================================
  // transmit sequencer
  always_comb
  begin
    d = q;
    tif.load = 1'b0;
    tif.done = 1'b0;
    to_stop = 1'b0;
    bit_end = tif.tick && (q.cnt == LAST_TICK);
    if (tif.tick)
      d.cnt = q.cnt + 4'h1;
    case (q.st)
      TX_IDLE:
        if (tif.pending)
        begin
          tif.load = 1'b1;
          d.sr = tif.data;
          d.st = TX_START;
          d.cnt = '0;
        end
      TX_START:
        if (bit_end)
        begin
          d.st = TX_DATA;
          d.idx = '0;
        end
      TX_DATA:
        if (bit_end)
        begin
          if (q.idx == (tif.chr7 ? 3'd6 : 3'd7))
          begin
            if (tif.mp || tif.pe)
            begin
              d.st = TX_PAR;
              // mp bit or parity over the sent bits only
              d.par = tif.mp ? tif.mp_bit_to_send
                : (^(q.sr & {~tif.chr7, 7'h7F})) ^ tif.odd;
            end
            else
              to_stop = 1'b1;
          end
          else
            d.idx = q.idx + 3'd1;
        end
      TX_PAR:
        if (bit_end)
          to_stop = 1'b1;
      TX_STOP1:
        if (bit_end)
          d.st = tif.stop2 ? TX_STOP2 : (q.nxt ? TX_START : TX_IDLE);
      default:
        if (bit_end)
          d.st = q.nxt ? TX_START : TX_IDLE;
    endcase
    // stop-bit time: chain the next frame or report the end
    if (to_stop)
    begin
      d.st = TX_STOP1;
      d.nxt = tif.pending;
      tif.load = tif.pending;
      tif.done = ~tif.pending;
      if (tif.pending)
        d.sr = tif.data;
    end
    if (!tif.te)
    begin
      d.st = TX_IDLE;
      d.nxt = 1'b0;
      tif.load = 1'b0;
      tif.done = 1'b0;
    end
    // line level per state
    case (d.st)
      TX_START: d.txd = 1'b0;
      TX_DATA:  d.txd = d.sr[d.idx];
      TX_PAR:   d.txd = d.par;
      default:  d.txd = 1'b1;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '{st: TX_IDLE, cnt: 4'h0, idx: 3'h0, sr: 8'h00, par: 1'b0, nxt: 1'b0, txd: 1'b1};
    else
      q <= d;
  end

  assign tif.txd = q.txd;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_start_low;
    q.st == TX_START |-> tif.txd == 1'b0;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not low");

  property p_tx_end_idle;
    tif.done |=> (tif.txd == 1'b1) [*8];
  endproperty
  a_tx_end_idle: assert property (p_tx_end_idle) else $error("line low after end");

  c_tx_end: cover property (tif.done);
endmodule : asr_tx

// >>> rtl/asr_tx_if.sv
interface asr_tx_if;
  logic       tick;
  logic       te;
  logic       pending;
  logic [7:0] data;
  logic       chr7;
  logic       pe;
  logic       odd;
  logic       mp;
  logic       mp_bit_to_send;
  logic       stop2;
  logic       load;
  logic       done;
  logic       txd;
  modport ctl (output tick, te, pending, data, chr7, pe, odd, mp, mp_bit_to_send, stop2,
               input load, done, txd);
  modport tx  (input tick, te, pending, data, chr7, pe, odd, mp, mp_bit_to_send, stop2,
               output load, done, txd);
endinterface : asr_tx_if
